// ---- design/flash_ctl_pkg.sv ----
// Constants, codes and state type for the flash program/erase controller
package flash_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_KEY      = 8'h04;
  localparam logic [7:0] OFS_ADDR     = 8'h08;
  localparam logic [7:0] OFS_DATA     = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int BIT_START  = 15;
  localparam int BIT_WRITE_ENABLE_BIT   = 14;
  localparam int BIT_WERR   = 13;
  localparam int BIT_LVERR  = 12;
  localparam int BIT_LVSTAT = 11;
  localparam int OP_W       = 4;

  // Operation codes; every other code performs nothing
  localparam logic [3:0] OP_NOP  = 4'h0;
  localparam logic [3:0] OP_WORD = 4'h1;
  localparam logic [3:0] OP_ROW  = 4'h3;
  localparam logic [3:0] OP_PAGE = 4'h4;
  localparam logic [3:0] OP_BULK = 4'h5;

  // Interrupt status and mask fields
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_W    = 2;

  // ----------------------------------------------------------------------
  // Reset values and the key register read value
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
  localparam logic [31:0] DATA_RST     = 32'h0000_0000;
  localparam logic [31:0] KEY_READ     = 32'h0000_0000;
  localparam logic [3:0]  OP_RST       = 4'h0;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

  // Unlock progress
  localparam logic [1:0] ARM_NONE = 2'h0;
  localparam logic [1:0] ARM_HALF = 2'h1;
  localparam logic [1:0] ARM_FULL = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_t;

endpackage : flash_ctl_pkg

// ---- design/flash_program_erase_control.sv ----
// Flash program/erase controller with AHB-Lite register slave
module flash_program_erase_control #(
  parameter logic [31:0] UNLOCK_KEY_FIRST  = 32'h1234_5678,
  parameter logic [31:0] UNLOCK_KEY_SECOND = 32'h8765_4321
) (
  // Clock and resets
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        POR_N_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  output logic [31:0]      HRDATA_OUT,
  // Flash array port
  output logic             FLASH_REQ_OUT,
  output logic [3:0]       FLASH_CMD_OUT,
  output logic [31:0]      FLASH_ADDR_OUT,
  output logic [31:0]      FLASH_WDATA_OUT,
  input  wire logic        FLASH_DONE_IN,
  input  wire logic        FLASH_ERR_IN,
  // Low-voltage detector, asynchronous
  input  wire logic        LOW_VOLT_IN,
  // Interrupt
  output logic             IRQ_OUT
);
  import flash_ctl_pkg::*;

  typedef struct packed {
    state_t           state;
    logic [1:0]       arm;
    logic             write_enable_bit;
    logic             werr;
    logic             lverr;
    logic [OP_W-1:0]  op;
    logic [31:0]      addr;
    logic             pend;
    logic             pend_write;
    logic [7:0]       pend_addr;
    logic             hreadyout;
    logic [31:0]      hrdata;
    logic             lv_meta;
    logic             lv_sync;
    logic             flash_req;
    logic [3:0]       flash_cmd;
    logic [31:0]      flash_addr;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic             irq;
  } regs_t;

  regs_t       st;
  regs_t       nx;
  logic [31:0] data_word;
  logic        data_wr;
  logic        start_ok;
  logic        wr_now;
  logic        rd_now;
  logic        busy;
  logic        real_op;

  assign busy    = (st.state == ST_BUSY);
  assign wr_now  = st.pend && st.pend_write;
  assign rd_now  = st.pend && !st.pend_write;
  assign real_op = (st.op == OP_WORD) || (st.op == OP_ROW) ||
                   (st.op == OP_PAGE) || (st.op == OP_BULK);
  // A start needs write enable, a completed key pair and an idle engine
  assign start_ok = wr_now && (st.pend_addr == OFS_CTRL) &&
                    HWDATA_IN[BIT_START] && st.write_enable_bit &&
                    (st.arm == ARM_FULL) && !busy;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [31:0]      rd;
    ev      = '0;
    rd      = 32'h0000_0000;
    nx      = st;
    data_wr = 1'b0;
    // Detector output is from another domain; second stage only is used
    nx.lv_meta   = LOW_VOLT_IN;
    nx.lv_sync   = st.lv_meta;
    nx.pend      = 1'b0;
    nx.hreadyout = 1'b1;

    // One wait state per transfer keeps HRDATA straight from a flop
    if (HSEL_IN && HREADY_IN && HTRANS_IN[1] && !st.pend) begin
      nx.pend       = 1'b1;
      nx.hreadyout  = 1'b0;
      nx.pend_write = HWRITE_IN;
      nx.pend_addr  = HADDR_IN[7:0];
    end

    if (rd_now) begin
      case (st.pend_addr)
        OFS_CTRL: begin
          rd[BIT_START]  = busy;
          rd[BIT_WRITE_ENABLE_BIT]   = st.write_enable_bit;
          rd[BIT_WERR]   = st.werr;
          rd[BIT_LVERR]  = st.lverr;
          rd[BIT_LVSTAT] = st.lv_sync;
          rd[OP_W-1:0]   = st.op;
        end
        OFS_KEY:      rd = KEY_READ;
        OFS_ADDR:     rd = st.addr;
        OFS_DATA:     rd = data_word;
        OFS_IRQ_STAT: begin
          rd[IRQ_W-1:0] = st.irq_status;
          nx.irq_status = '0;
        end
        OFS_IRQ_MASK: rd[IRQ_W-1:0] = st.irq_mask;
        default:      rd = 32'h0000_0000;
      endcase
      nx.hrdata = rd;
    end

    if (wr_now) begin
      case (st.pend_addr)
        OFS_CTRL: begin
          nx.write_enable_bit = HWDATA_IN[BIT_WRITE_ENABLE_BIT];
          // Operation code is frozen while writes are enabled
          if (!st.write_enable_bit) begin
            nx.op = HWDATA_IN[OP_W-1:0];
          end
          // Any control write spends the unlock
          nx.arm = ARM_NONE;
        end
        OFS_KEY: begin
          if (HWDATA_IN == UNLOCK_KEY_FIRST) begin
            nx.arm = ARM_HALF;
          end else if (st.arm == ARM_HALF &&
                       HWDATA_IN == UNLOCK_KEY_SECOND) begin
            nx.arm = ARM_FULL;
          end else begin
            nx.arm = ARM_NONE;
          end
        end
        OFS_ADDR:     nx.addr = HWDATA_IN;
        OFS_DATA:     data_wr = 1'b1;
        OFS_IRQ_MASK: nx.irq_mask = HWDATA_IN[IRQ_W-1:0];
        default: ;
      endcase
    end

    case (st.state)
      ST_IDLE: begin
        if (start_ok) begin
          if (st.lv_sync) begin
            // Supply too low: refuse and flag both errors
            nx.werr     = 1'b1;
            nx.lverr    = 1'b1;
            ev[IRQ_ERR] = 1'b1;
          end else if (real_op) begin
            nx.state     = ST_BUSY;
            nx.flash_req = 1'b1;
            nx.flash_cmd = st.op;
            if (st.op == OP_BULK) begin
              nx.flash_addr = 32'h0000_0000;
            end else begin
              nx.flash_addr = st.addr;
            end
          end else begin
            if (st.op == OP_NOP) begin
              nx.werr  = 1'b0;
              nx.lverr = 1'b0;
            end
            ev[IRQ_DONE] = 1'b1;
          end
        end
      end
      ST_BUSY: begin
        if (FLASH_DONE_IN) begin
          nx.state     = ST_IDLE;
          nx.flash_req = 1'b0;
          nx.write_enable_bit      = 1'b0;
          ev[IRQ_DONE] = 1'b1;
          if (FLASH_ERR_IN) begin
            nx.werr     = 1'b1;
            ev[IRQ_ERR] = 1'b1;
          end
        end
      end
      default: begin
        nx.state     = ST_IDLE;
        nx.flash_req = 1'b0;
      end
    endcase

    // New events win over a clearing read in the same cycle
    nx.irq_status = nx.irq_status | ev;
    nx.irq        = |(nx.irq_status & nx.irq_mask);
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st            <= '0;
      st.state      <= ST_IDLE;
      st.arm        <= ARM_NONE;
      st.op         <= OP_RST;
      st.addr       <= ADDR_RST;
      st.hreadyout  <= 1'b1;
      st.irq_mask   <= IRQ_MASK_RST;
    end else begin
      st <= nx;
    end
  end

  // Data word survives every reset except power-on
  always_ff @(posedge SYS_CLK_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      data_word <= DATA_RST;
    end else if (data_wr) begin
      data_word <= HWDATA_IN;
    end
  end

  assign HREADYOUT_OUT   = st.hreadyout;
  assign HRESP_OUT       = 1'b0;
  assign HRDATA_OUT      = st.hrdata;
  assign FLASH_REQ_OUT   = st.flash_req;
  assign FLASH_CMD_OUT   = st.flash_cmd;
  assign FLASH_ADDR_OUT  = st.flash_addr;
  assign FLASH_WDATA_OUT = data_word;
  assign IRQ_OUT         = st.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  key_arm_pair_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    wr_now && st.pend_addr == OFS_KEY && st.arm == ARM_HALF &&
    HWDATA_IN == UNLOCK_KEY_SECOND |=> st.arm == ARM_FULL)
    else $error("second key did not complete unlock");

  key_reads_zero_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    rd_now && st.pend_addr == OFS_KEY |=> HRDATA_OUT == 32'h0 &&
    HREADYOUT_OUT)
    else $error("key register read not zero");

  start_needs_unlock_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    $rose(FLASH_REQ_OUT) |-> $past(st.arm) == ARM_FULL && $past(st.write_enable_bit))
    else $error("flash started without unlock");

  addr_readback_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    rd_now && st.pend_addr == OFS_ADDR |=> HRDATA_OUT == $past(st.addr))
    else $error("address register readback wrong");

  bulk_addr_zero_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    FLASH_REQ_OUT && FLASH_CMD_OUT == OP_BULK |-> FLASH_ADDR_OUT == 32'h0)
    else $error("bulk erase carried an address");

  page_addr_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    start_ok && !st.lv_sync && st.op == OP_PAGE |=>
    FLASH_REQ_OUT && FLASH_ADDR_OUT == $past(st.addr))
    else $error("page erase address wrong");

  row_addr_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    start_ok && !st.lv_sync && st.op == OP_ROW |=>
    FLASH_CMD_OUT == OP_ROW && FLASH_ADDR_OUT == $past(st.addr))
    else $error("row program address wrong");

  word_data_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    start_ok && !st.lv_sync && st.op == OP_WORD |=>
    FLASH_ADDR_OUT == $past(st.addr) && FLASH_WDATA_OUT == $past(data_word))
    else $error("word program address or data wrong");

  nop_clears_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    start_ok && !st.lv_sync && st.op == OP_NOP |=>
    !st.werr && !st.lverr && !FLASH_REQ_OUT)
    else $error("no-op start left error flags");

  data_hold_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!POR_N_IN)
    data_word != $past(data_word) |-> $past(data_wr))
    else $error("data register changed without write");

  reserved_idle_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    start_ok && !real_op |=> !FLASH_REQ_OUT [*2])
    else $error("reserved code reached flash");

endmodule : flash_program_erase_control

// ---- bench/flash_array_model.sv ----
// Behavioural flash array that answers program and erase requests
module flash_array_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Request side
  input  wire logic req_in,
  input  wire logic slow_in,
  input  wire logic fail_in,
  output logic      done_out,
  output logic      err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Error only means something with done, so it toggles otherwise
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt      <= 4'h0;
      done_out <= 1'b0;
      err_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      err_out  <= ~err_out;
      if (req_in && !done_out) begin
        cnt <= cnt + 4'h1;
        if (cnt == (slow_in ? 4'h6 : 4'h0)) begin
          done_out <= 1'b1;
          err_out  <= fail_in;
          cnt      <= 4'h0;
        end
      end
    end
  end
endmodule : flash_array_model

// ---- bench/tb.sv ----
// Self-checking bench for the flash program/erase controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctl_pkg::*;
  localparam logic [31:0] K1 = 32'h1357_9bdf;
  localparam logic [31:0] K2 = 32'h2468_ace0;
  localparam logic [31:0] WE = 32'h1 << BIT_WRITE_ENABLE_BIT;
  localparam logic [31:0] EB = (32'h1 << BIT_WERR) | (32'h1 << BIT_LVERR);
  logic        clk = 0, rstn = 0, por_n = 0, sel = 0, wr = 0;
  logic        lv = 0, slow = 0, fail = 0, rp = 0, rq = 0;
  logic [1:0]  trans = 2'h0;
  logic [2:0]  size = 3'h0;
  logic [31:0] addr = 0, wdata = 0, r, a, d;
  logic        rdy, resp, req, done, ferr, irq;
  logic [3:0]  cmd;
  logic [31:0] rdata, faddr, fwdata;
  logic [63:0] me;
  logic [63:0] q_rd[$];
  logic [67:0] q_op[$];
  logic [7:0]  ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [3:0]  c4[4] = '{OP_WORD, OP_ROW, OP_PAGE, OP_BULK};
  logic [3:0]  c5[5] = '{OP_NOP, 4'h2, 4'h6, 4'h7, 4'hf};
  int          n_mismatch = 0, n_compared = 0;

  always #4 clk = ~clk;

  flash_program_erase_control #(
    .UNLOCK_KEY_FIRST (K1),
    .UNLOCK_KEY_SECOND(K2)
  ) flash_program_erase_control_i (
    .SYS_CLK_IN     (clk),
    .RESETN_IN      (rstn),
    .POR_N_IN       (por_n),
    .HSEL_IN        (sel),
    .HADDR_IN       (addr),
    .HTRANS_IN      (trans),
    .HWRITE_IN      (wr),
    .HSIZE_IN       (size),
    .HWDATA_IN      (wdata),
    .HREADY_IN      (rdy),
    .HREADYOUT_OUT  (rdy),
    .HRESP_OUT      (resp),
    .HRDATA_OUT     (rdata),
    .FLASH_REQ_OUT  (req),
    .FLASH_CMD_OUT  (cmd),
    .FLASH_ADDR_OUT (faddr),
    .FLASH_WDATA_OUT(fwdata),
    .FLASH_DONE_IN  (done),
    .FLASH_ERR_IN   (ferr),
    .LOW_VOLT_IN    (lv),
    .IRQ_OUT        (irq)
  );

  flash_array_model flash_array_model_i (
    .clk_in  (clk),
    .rst_n_in(rstn),
    .req_in  (req),
    .slow_in (slow),
    .fail_in (fail),
    .done_out(done),
    .err_out (ferr)
  );

  task chk(input string n, input logic [67:0] e, input logic [67:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : wait_rdy

  // Rdata is read before the edge's updates land, so it is the answer
  task bus(input logic w, input logic [7:0] o, input logic [31:0] v,
           input logic [63:0] m);
    if (!w) q_rd.push_back(m);
    @(posedge clk);
    sel   <= 1'b1;
    trans <= 2'h2;
    wr    <= w;
    addr  <= {24'h0, o};
    size  <= 3'h2;
    wait_rdy;
    sel   <= 1'b0;
    trans <= 2'h0;
    wdata <= v;
    wait_rdy;
    r = rdata;
  endtask : bus

  task w32(input logic [7:0] o, input logic [31:0] v);
    bus(1'b1, o, v, 64'h0);
  endtask : w32

  task r32(input logic [7:0] o, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, o, 32'h0, {m, e});
  endtask : r32

  task tend(input string n);
    $display("test %s done", n);
  endtask : tend

  task op(input logic [3:0] c, input logic go);
    int i;
    a = $urandom;
    d = $urandom;
    w32(OFS_ADDR, a);
    w32(OFS_DATA, d);
    w32(OFS_CTRL, 32'h0);
    w32(OFS_CTRL, WE | {28'h0, c});
    w32(OFS_KEY, K1);
    w32(OFS_KEY, K2);
    if (go) q_op.push_back({c, (c == OP_BULK) ? 32'h0 : a, d});
    w32(OFS_CTRL, (32'h1 << BIT_START) | WE | {28'h0, c});
    i = 0;
    do begin
      bus(1'b0, OFS_CTRL, 32'h0, 64'h0);
      i++;
    end while (r[BIT_START] !== 1'b0 && i < 50);
    // A stuck busy bit is a failure in its own right
    if (r[BIT_START] !== 1'b0) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : op

  // A zero mask marks a poll whose value is not judged
  always @(posedge clk) begin
    if (rp && rdy) begin
      me = q_rd.pop_front();
      if (me[63:32] != 0) chk("rdata", me[31:0], rdata & me[63:32]);
      rp = 0;
    end
    if (sel && trans[1] && rdy && !wr) rp = 1;
    if (req && !rq) begin
      if (q_op.size() == 0) chk("stray op", 68'h0, 68'h1);
      else chk("flash op", q_op.pop_front(), {cmd, faddr, fwdata});
    end
    rq = req;
  end

  initial begin
    r = $urandom(57);
    repeat (20) @(posedge clk);
    rstn  <= 1'b1;
    por_n <= 1'b1;
    foreach (ofs[i]) r32(ofs[i], '1, 32'h0);
    tend("reset values");
    a = $urandom;
    w32(OFS_KEY, a);
    r32(OFS_KEY, '1, KEY_READ);
    w32(OFS_ADDR, a);
    r32(OFS_ADDR, '1, a);
    tend("key and address");
    foreach (c4[i]) begin
      slow <= i[0];
      op(c4[i], 1'b1);
    end
    chk("irq masked", 68'h0, irq);
    w32(OFS_IRQ_MASK, 32'h1 << IRQ_DONE);
    repeat (2) @(posedge clk);
    chk("irq raised", 68'h1, irq);
    r32(OFS_IRQ_STAT, 32'h3, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 68'h0, irq);
    tend("operations");
    w32(OFS_CTRL, 32'h0);
    w32(OFS_CTRL, WE | OP_WORD);
    w32(OFS_KEY, K2);
    w32(OFS_KEY, K1);
    w32(OFS_CTRL, (32'h1 << BIT_START) | WE | OP_WORD);
    repeat (4) @(posedge clk);
    r32(OFS_CTRL, 32'h1 << BIT_START, 32'h0);
    tend("locked start");
    fail <= 1'b1;
    op(OP_PAGE, 1'b1);
    fail <= 1'b0;
    r32(OFS_CTRL, 32'h1 << BIT_WERR, 32'h1 << BIT_WERR);
    lv <= 1'b1;
    repeat (4) @(posedge clk);
    r32(OFS_CTRL, 32'h1 << BIT_LVSTAT, 32'h1 << BIT_LVSTAT);
    op(OP_WORD, 1'b0);
    lv <= 1'b0;
    r32(OFS_CTRL, EB, EB);
    repeat (4) @(posedge clk);
    foreach (c5[i]) begin
      op(c5[i], 1'b0);
      if (i == 0) r32(OFS_CTRL, EB, 32'h0);
    end
    r32(OFS_IRQ_STAT, 32'h3, 32'h3);
    tend("errors and no-op");
    d = $urandom;
    w32(OFS_DATA, d);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    r32(OFS_DATA, '1, d);
    por_n <= 1'b0;
    rstn  <= 1'b0;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    rstn  <= 1'b1;
    r32(OFS_DATA, '1, DATA_RST);
    chk("hresp", 68'h0, resp);
    tend("resets");
    end_of_test;
  end
endmodule : tb
